// ===== hw/amas_phase_counter.sv
// Down counter timing one sequencer phase.
// Assumes the caller loads it on every phase entry; asynchronous reset from the synchronised reset copy.
module amas_phase_counter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [amas_pkg::CNT_W-1:0] load_val,
  output logic expired
);
  import amas_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Phase lasts load_val + 1 cycles; counter parks at zero
  assign cnt_nxt = load ? load_val : (expired ? cnt_r : cnt_r - 6'h01);
  assign expired = (cnt_r == CNT_RST);

  ////////////////////////////////////////////////////////////////////////
  // Count register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ===== hw/amas_pkg.sv
// Shared constants and types for the asynchronous memory access sequencer.
// Assumes a single 100 MHz interface clock and a 16-bit external data bus.
package amas_pkg;

  // Bus widths
  localparam int ADDR_W = 23;
  localparam int BANK_W = 2;
  localparam int SPACE_W = 2;
  localparam int WORD_W = 32;
  localparam int EXT_W = 16;

  // Timing field widths, in interface clock cycles
  localparam int TA_W = 2;
  localparam int SETUP_W = 4;
  localparam int STROBE_W = 6;
  localparam int HOLD_W = 3;
  localparam int CNT_W = 6;
  localparam int BEAT_W = 2;

  // Beats per word, minus one, by device width
  localparam logic [BEAT_W-1:0] BEATS_M1_8BIT = 2'h3;
  localparam logic [BEAT_W-1:0] BEATS_M1_16BIT = 2'h1;
  localparam logic WIDTH_16BIT = 1'b1;

  // Reset values and turnaround constants
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 23'h00_0000;
  localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
  localparam logic [EXT_W-1:0] EXT_RST = 16'h0000;
  localparam logic [TA_W-1:0] TA_ZERO = 2'h0;
  localparam logic [TA_W:0] TA_MIN = 3'h1;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TURN = 3'h1,
    ST_SETUP = 3'h2,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h4
  } amas_state_t;

endpackage

// ===== hw/amas_sequencer.sv
// Normal-mode sequencer for asynchronous external memory accesses.
// Assumes timing config inputs describe the requested space and stay stable
// from request acceptance to the end of the access.

// Functional notes
// - Read output enable rises at start of hold.
// - External data sampled at hold start becomes the read result.
// - Address and bank outputs released after the word's last hold, unless a chained setup follows.
// - Chip select rises at hold end only when request is complete.
// - Narrow device follow-on beats go straight to setup, no turnaround.
// - Follow-on beats reuse already loaded setup, strobe and hold counts.
// - After full word, return to idle unless another request is pending.
// - Pending request at completion goes directly to its turnaround, or straight to setup if same direction and space.
// - Writes needing several external cycles issue them back to back.
// - Output enable stays high throughout every write.
// - Write waits programmed turnaround cycles before setup.
// - No turnaround for write chained after write to same space.
// - Turnaround field zero still gives one turnaround cycle.
// - After turnaround, write proceeds into its setup period.
// - Reads use the same turnaround policy as writes.
// - Read setup loads counts, presents address, asserts chip select.
// - Read output enable falls at start of strobe.
// - Write setup loads write setup, strobe and hold counts.
module amas_sequencer (
  input wire logic clk_sys,
  input wire logic arst_n,
  // Request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [amas_pkg::SPACE_W-1:0] req_space,
  input wire logic [amas_pkg::ADDR_W-1:0] req_addr,
  input wire logic [amas_pkg::BANK_W-1:0] req_bank,
  input wire logic [amas_pkg::WORD_W-1:0] req_wdata,
  output logic req_ready,
  output logic [amas_pkg::WORD_W-1:0] rd_data,
  output logic rd_valid,
  output logic wr_done,
  output logic busy,
  // Space configuration for the requested space
  input wire logic [amas_pkg::TA_W-1:0] turnaround_cycles,
  input wire logic [amas_pkg::SETUP_W-1:0] cfg_r_setup,
  input wire logic [amas_pkg::STROBE_W-1:0] cfg_r_strobe,
  input wire logic [amas_pkg::HOLD_W-1:0] cfg_r_hold,
  input wire logic [amas_pkg::SETUP_W-1:0] cfg_w_setup,
  input wire logic [amas_pkg::STROBE_W-1:0] cfg_w_strobe,
  input wire logic [amas_pkg::HOLD_W-1:0] cfg_w_hold,
  input wire logic cfg_width_16,
  // External memory pins
  output logic [amas_pkg::ADDR_W-1:0] ext_address,
  output logic [amas_pkg::BANK_W-1:0] ext_bank_address,
  output logic ext_chip_select_n,
  output logic ext_output_enable_n,
  output logic ext_write_enable_n,
  output logic ext_rw,
  output logic [amas_pkg::EXT_W-1:0] ext_data_bus_out,
  output logic ext_data_bus_oe,
  input wire logic [amas_pkg::EXT_W-1:0] ext_data_bus_in
);
  import amas_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic rst_meta_r;
  logic rst_n;
  logic [EXT_W-1:0] din_meta_r;
  logic [EXT_W-1:0] din_sync_r;

  // Reset asserts at once, releases after two edges
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Read data is a pin; two stages before anyone looks at it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      din_meta_r <= EXT_RST;
      din_sync_r <= EXT_RST;
    end else begin
      din_meta_r <= ext_data_bus_in;
      din_sync_r <= din_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  amas_state_t state_r;
  amas_state_t state_nxt;
  logic write_r;
  logic [SPACE_W-1:0] space_r;
  logic [ADDR_W-1:0] addr_r;
  logic [BANK_W-1:0] bank_r;
  logic [WORD_W-1:0] wdata_r;
  logic [WORD_W-1:0] rdata_r;
  logic [BEAT_W-1:0] beat_r;
  logic [BEAT_W-1:0] beats_m1_r;
  logic [SETUP_W-1:0] tim_setup_r;
  logic [STROBE_W-1:0] tim_strobe_r;
  logic [HOLD_W-1:0] tim_hold_r;
  logic rd_valid_r, wr_done_r, cs_n_r, oe_n_r, we_n_r, rw_r, doe_r;
  logic [EXT_W-1:0] dout_r;
  logic [ADDR_W-1:0] ext_addr_r;
  logic [BANK_W-1:0] ext_bank_r;
  logic expired;

  // Phase decode
  wire in_idle = (state_r == ST_IDLE);
  wire in_hold = (state_r == ST_HOLD);
  wire beat_last = (beat_r == beats_m1_r);
  wire hold_done = in_hold && expired;
  wire word_done = hold_done && beat_last;
  wire more_beats = hold_done && !beat_last;
  wire accept = req_valid && (in_idle || word_done);
  // Back-to-back same direction, same space: no turnaround
  wire same_chain = word_done && (req_write == write_r) && (req_space == space_r);
  wire [TA_W:0] ta_eff = (turnaround_cycles == TA_ZERO) ? TA_MIN : {1'b0, turnaround_cycles};
  wire turn_done = (state_r == ST_TURN) && expired;
  wire first_setup = (accept && same_chain) || turn_done;
  wire enter_setup = first_setup || more_beats;
  wire enter_strobe = (state_r == ST_SETUP) && expired;
  wire enter_hold = (state_r == ST_STROBE) && expired;
  wire nxt_write = accept ? req_write : write_r;
  wire [SETUP_W-1:0] cfg_setup = nxt_write ? cfg_w_setup : cfg_r_setup;
  wire [BEAT_W-1:0] nxt_beat = more_beats ? beat_r + 2'h1 : beat_r;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = accept ? (same_chain ? ST_SETUP : ST_TURN) : ST_IDLE;
      ST_TURN: state_nxt = expired ? ST_SETUP : ST_TURN;
      ST_SETUP: state_nxt = expired ? ST_STROBE : ST_SETUP;
      ST_STROBE: state_nxt = expired ? ST_HOLD : ST_STROBE;
      ST_HOLD: begin
        if (more_beats) begin
          state_nxt = ST_SETUP;
        end else if (word_done) begin
          state_nxt = accept ? (same_chain ? ST_SETUP : ST_TURN) : ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Counter load on every phase entry; turnaround loads count minus one
  wire cnt_load = (accept && !same_chain) || enter_setup || enter_strobe || enter_hold;
  wire [CNT_W-1:0] turn_val = CNT_W'(ta_eff - TA_MIN);
  wire [CNT_W-1:0] setup_val = CNT_W'(first_setup ? cfg_setup : tim_setup_r);
  wire [CNT_W-1:0] cnt_val = enter_setup ? setup_val :
                             enter_strobe ? CNT_W'(tim_strobe_r) :
                             enter_hold ? CNT_W'(tim_hold_r) : turn_val;

  amas_phase_counter u_phase (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(cnt_load),
    .load_val(cnt_val),
    .expired(expired)
  );

  // Lane slices for the beat being issued
  wire [EXT_W-1:0] wr_slice = cfg_width_16 ? wdata_r[nxt_beat*16 +: 16]
                                           : {8'h00, wdata_r[nxt_beat*8 +: 8]};

  ////////////////////////////////////////////////////////////////////////
  // Request capture and timing registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      write_r <= 1'b0;
      space_r <= 2'h0;
      addr_r <= ADDR_RST;
      bank_r <= BANK_RST;
      wdata_r <= WORD_RST;
      beat_r <= 2'h0;
      beats_m1_r <= BEATS_M1_8BIT;
    end else begin
      state_r <= state_nxt;
      beat_r <= nxt_beat;
      if (accept) begin
        write_r <= req_write;
        space_r <= req_space;
        addr_r <= req_addr;
        bank_r <= req_bank;
        wdata_r <= req_wdata;
        beat_r <= 2'h0;
        beats_m1_r <= (cfg_width_16 == WIDTH_16BIT) ? BEATS_M1_16BIT : BEATS_M1_8BIT;
      end
    end
  end

  // Counts latched only on the first beat so follow-ons keep them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tim_setup_r <= 4'h0;
      tim_strobe_r <= 6'h00;
      tim_hold_r <= 3'h0;
    end else if (first_setup) begin
      tim_setup_r <= cfg_setup;
      tim_strobe_r <= nxt_write ? cfg_w_strobe : cfg_r_strobe;
      tim_hold_r <= nxt_write ? cfg_w_hold : cfg_r_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read capture; synchronised pin data lags the pin by two cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= WORD_RST;
      rd_valid_r <= 1'b0;
      wr_done_r <= 1'b0;
    end else begin
      rd_valid_r <= word_done && !write_r;
      wr_done_r <= word_done && write_r;
      if (enter_hold && !write_r) begin
        if (cfg_width_16) begin
          rdata_r[beat_r*16 +: 16] <= din_sync_r;
        end else begin
          rdata_r[beat_r*8 +: 8] <= din_sync_r[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin strobes; later assignments win so a chained setup keeps CS low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      rw_r <= 1'b1;
      doe_r <= 1'b0;
    end else begin
      if (word_done) begin
        cs_n_r <= 1'b1;
        rw_r <= 1'b1;
        doe_r <= 1'b0;
      end
      if (enter_setup) begin
        cs_n_r <= 1'b0;
        rw_r <= !nxt_write;
        doe_r <= nxt_write;
      end
      if (enter_strobe) begin
        oe_n_r <= write_r;
        we_n_r <= !write_r;
      end
      if (enter_hold) begin
        oe_n_r <= 1'b1;
        we_n_r <= 1'b1;
      end
    end
  end

  // Address and write data; cleared at word end to show release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_addr_r <= ADDR_RST;
      ext_bank_r <= BANK_RST;
      dout_r <= EXT_RST;
    end else if (enter_setup) begin
      ext_addr_r <= accept ? req_addr : addr_r + ADDR_W'(nxt_beat);
      ext_bank_r <= accept ? req_bank : bank_r;
      dout_r <= accept ? (cfg_width_16 ? req_wdata[15:0] : {8'h00, req_wdata[7:0]}) : wr_slice;
    end else if (word_done) begin
      ext_addr_r <= ADDR_RST;
      ext_bank_r <= BANK_RST;
      dout_r <= EXT_RST;
    end
  end

  // Outputs
  assign req_ready = accept;
  assign rd_data = rdata_r;
  assign rd_valid = rd_valid_r;
  assign wr_done = wr_done_r;
  assign busy = !in_idle;
  assign ext_address = ext_addr_r;
  assign ext_bank_address = ext_bank_r;
  assign ext_chip_select_n = cs_n_r;
  assign ext_output_enable_n = oe_n_r;
  assign ext_write_enable_n = we_n_r;
  assign ext_rw = rw_r;
  assign ext_data_bus_out = dout_r;
  assign ext_data_bus_oe = doe_r;

endmodule

// ===== tb/amas_seq_assertions.sv
// Pin-level assertions for the asynchronous memory access sequencer.
// Assumes one clock domain; bound to every amas_sequencer instance.
module amas_seq_assertions (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic busy,
  input wire logic rd_valid,
  input wire logic wr_done,
  input wire logic [amas_pkg::TA_W-1:0] turnaround_cycles,
  input wire logic [amas_pkg::STROBE_W-1:0] cfg_r_strobe,
  input wire logic [amas_pkg::ADDR_W-1:0] ext_address,
  input wire logic [amas_pkg::BANK_W-1:0] ext_bank_address,
  input wire logic ext_chip_select_n,
  input wire logic ext_output_enable_n,
  input wire logic ext_write_enable_n,
  input wire logic ext_rw,
  input wire logic ext_data_bus_oe
);
  import amas_pkg::*;
  logic [6:0] oe_cnt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ////////////////////
  // Length of the read strobe; a counter, since the field is too wide to unroll
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) oe_cnt_r <= 7'h00;
    else oe_cnt_r <= ext_output_enable_n ? 7'h00 : oe_cnt_r + 7'h01;
  end
  ////////////////////
  a_oe_write_high: assert property (!ext_rw |-> ext_output_enable_n)
    else $error("read strobe active during a write");
  a_strobe_len: assert property ($rose(ext_output_enable_n) |->
    oe_cnt_r == {1'b0, cfg_r_strobe} + 7'h01)
    else $error("read strobe length wrong");
  a_oe_needs_sel: assert property (!ext_output_enable_n |-> !ext_chip_select_n && ext_rw)
    else $error("read strobe without select");
  a_setup_first: assert property ($fell(ext_output_enable_n) |->
    $past(ext_chip_select_n) == 1'b0)
    else $error("strobe began without setup");
  a_addr_idle_zero: assert property (ext_chip_select_n |->
    ext_address == ADDR_RST && ext_bank_address == BANK_RST)
    else $error("address held outside access");
  a_turn_zero: assert property ($rose(busy) && turnaround_cycles == TA_ZERO |->
    ext_chip_select_n ##1 !ext_chip_select_n)
    else $error("zero turnaround not one cycle");
  a_turn_two: assert property ($rose(busy) && turnaround_cycles == 2'h2 |->
    ext_chip_select_n [*2] ##1 !ext_chip_select_n)
    else $error("turnaround of two wrong");
  a_idle_after_word: assert property ((rd_valid || wr_done) && !$past(req_valid) |-> !busy)
    else $error("sequencer not idle after word");
  a_cs_rise_end: assert property (rd_valid && !busy |->
    ext_chip_select_n && $past(ext_chip_select_n) == 1'b0)
    else $error("select not released at read end");
  a_we_in_write: assert property (!ext_write_enable_n |-> !ext_rw && ext_data_bus_oe)
    else $error("write strobe outside write");
  c_read: cover property (rd_valid);
  c_write: cover property (wr_done);
  c_chain: cover property (req_ready && busy);
endmodule
bind amas_sequencer amas_seq_assertions u_chk (.clk_sys, .arst_n, .req_valid, .req_ready,
  .busy, .rd_valid, .wr_done, .turnaround_cycles, .cfg_r_strobe, .ext_address,
  .ext_bank_address, .ext_chip_select_n, .ext_output_enable_n, .ext_write_enable_n,
  .ext_rw, .ext_data_bus_oe);

// ===== tb/amas_sram_model.sv
// Behavioural asynchronous SRAM on the external pins, 16 locations.
// Assumes a 16-bit bus; an 8-bit device uses the low byte only.
module amas_sram_model (
  input wire logic clk_sys,
  input wire logic [amas_pkg::ADDR_W-1:0] ext_address,
  input wire logic ext_chip_select_n,
  input wire logic ext_output_enable_n,
  input wire logic ext_write_enable_n,
  input wire logic [amas_pkg::EXT_W-1:0] ext_data_bus_out,
  output logic [amas_pkg::EXT_W-1:0] ext_data_bus_in
);
  import amas_pkg::*;
  logic [EXT_W-1:0] mem [16];
  logic [EXT_W-1:0] last_r;
  logic drive;
  // Known pattern so reads before writes have a checkable word
  initial begin
    last_r = EXT_RST;
    for (int i = 0; i < 16; i++) mem[i] = 16'(16'h1111 * i);
  end
  assign drive = !ext_chip_select_n && !ext_output_enable_n;
  // Released bus shows the inverse of the last word, never a held copy
  assign ext_data_bus_in = drive ? mem[ext_address[3:0]] : ~last_r;
  // Store on each write-strobe cycle; the last before the rise wins
  always @(posedge clk_sys) begin
    if (drive) last_r <= mem[ext_address[3:0]];
    if (!ext_chip_select_n && !ext_write_enable_n) mem[ext_address[3:0]] <= ext_data_bus_out;
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the asynchronous memory access sequencer.
// Assumes the SRAM model on the pins; inputs change on the falling edge.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import amas_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, cfg_width_16 = 1'b1;
  logic [1:0] req_space = 2'h0, req_bank = 2'h0, turnaround_cycles = 2'h0;
  logic [22:0] req_addr = 23'h00_0000;
  logic [31:0] req_wdata = 32'h0000_0000, rd_data;
  logic [3:0] cfg_r_setup = 4'h0, cfg_w_setup = 4'h0;
  logic [5:0] cfg_r_strobe = 6'h02, cfg_w_strobe = 6'h02;
  logic [2:0] cfg_r_hold = 3'h0, cfg_w_hold = 3'h0;
  logic req_ready, rd_valid, wr_done, busy, ext_chip_select_n, ext_output_enable_n;
  logic ext_write_enable_n, ext_rw, ext_data_bus_oe;
  logic [22:0] ext_address;
  logic [1:0] ext_bank_address;
  logic [15:0] ext_data_bus_out, ext_data_bus_in;
  int error_cnt = 0, n_tests = 0;
  amas_sequencer uut (.*);
  amas_sram_model u_mem (.*);
  always #5 clk_sys = ~clk_sys;
  ////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Same timing for both directions, but read hold one longer to tell them apart
  task automatic cfg(input logic [1:0] ta, input logic w16, input logic [3:0] s,
      input logic [5:0] p, input logic [2:0] h);
    turnaround_cycles = ta;
    cfg_width_16 = w16;
    cfg_r_setup = s;
    cfg_w_setup = s;
    cfg_r_strobe = p;
    cfg_w_strobe = p;
    cfg_r_hold = h + 3'h1;
    cfg_w_hold = h;
  endtask
  // One request; hold keeps valid up so the next one chains
  task automatic do_req(input logic wr, input logic [22:0] a, input logic [31:0] wd,
      input bit hold, output logic [31:0] lat);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    n = 0;
    #1;
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 200) begin
        chk("req_ready", 32'h1, 32'h0);
        tally_and_finish();
      end
      @(negedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    lat = 32'h0;
    if (hold) return;
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 1;
    // A pulse while still busy belongs to an earlier chained request
    while (!((rd_valid === 1'b1 || wr_done === 1'b1) && busy === 1'b0)) begin
      @(negedge clk_sys);
      n++;
      if (n > 200) begin
        chk("completion", 32'h1, 32'h0);
        tally_and_finish();
      end
    end
    lat = 32'(n);
  endtask
  ////////////////////
  task automatic t_read16();
    logic [31:0] lat;
    cfg(2'h1, 1'b1, 4'h0, 6'h02, 3'h0);
    do_req(1'b0, 23'h00_0002, 32'h0000_0000, 1'b0, lat);
    chk("read16 data", 32'h3333_2222, rd_data);
    chk("read16 cycles", 32'd14, lat);
    $display("read16 test done");
  endtask
  task automatic t_write8();
    logic [31:0] lat;
    cfg(2'h0, 1'b0, 4'h1, 6'h02, 3'h0);
    do_req(1'b1, 23'h00_0004, 32'hA5C3_1E7B, 1'b0, lat);
    chk("write8 cycles", 32'd26, lat);
    $display("write8 test done");
  endtask
  task automatic t_read8();
    logic [31:0] lat;
    cfg(2'h2, 1'b0, 4'h1, 6'h02, 3'h0);
    do_req(1'b0, 23'h00_0004, 32'h0000_0000, 1'b0, lat);
    chk("read8 data", 32'hA5C3_1E7B, rd_data);
    chk("read8 cycles", 32'd31, lat);
    $display("read8 test done");
  endtask
  // Write chained on write, a read paying full turnaround, then a read from idle and one chained on it paying none
  task automatic t_chain();
    logic [31:0] lat;
    cfg(2'h3, 1'b1, 4'h0, 6'h02, 3'h0);
    req_space = 2'h1;
    req_bank = 2'h2;
    do_req(1'b1, 23'h00_0008, 32'hBEEF_CAFE, 1'b1, lat);
    do_req(1'b1, 23'h00_000A, 32'h1234_5678, 1'b0, lat);
    chk("chained write cycles", 32'd11, lat);
    do_req(1'b0, 23'h00_0008, 32'h0000_0000, 1'b0, lat);
    chk("chain read data", 32'hBEEF_CAFE, rd_data);
    chk("chain read cycles", 32'd16, lat);
    do_req(1'b0, 23'h00_0008, 32'h0000_0000, 1'b1, lat);
    do_req(1'b0, 23'h00_000A, 32'h0000_0000, 1'b0, lat);
    chk("chained read data", 32'h1234_5678, rd_data);
    chk("chained read cycles", 32'd13, lat);
    $display("chain test done");
  endtask
  ////////////////////
  // Reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_read16();
    t_write8();
    t_read8();
    t_chain();
    tally_and_finish();
  end
endmodule
